// ### sdi_framer_pkg.sv
// Notes on behaviour
// [RULE1] take one 10-bit word per clock; find 30-bit preamble at any bit position
// [RULE2] search 39 bits: three pipeline words plus nine low input bits
// [RULE3] encode preamble start as offset; compare with held offset
// [RULE4] new-offset flag from compare; load offset only on realignment
// [RULE5] offset steers shifter picking 10-bit word from 19-bit slice
// [RULE6] one scrambled word in, one descrambled framed word out per clock
// [RULE7] filter low: always realign; high: ignore single off-offset preamble
// [RULE8] async-serial mode high: pass input words through unchanged
// [RULE9] bypass high with async mode low also passes through, muxed before output reg
// [RULE10] receiver mode output is async mode inverted and registered
// [RULE11] line toggle flips on every detection while async mode is high, filtered ones included
// [RULE12] line toggle holds while async mode is low
// [RULE13] filtered off-offset preamble gives exactly one-cycle error pulse
// [RULE14] preamble is ten ones then twenty zeros
// [RULE15] new-offset flag holds until matching preamble or one while realign allowed
// [RULE16] realign disallowed: detect offsets, keep offset register
// [RULE17] timing marker high for four preamble words, even if misframed
// [RULE18] filter low forces realign allowed; high routes flag to realign allow
// [RULE19] reset clears offset, pipes, toggle, error; unframed until first preamble
`default_nettype none
package sdi_framer_pkg;
    localparam int WORD_W = 10;
    localparam int VEC_W = 39;
    localparam int SLICE_W = 19;
    localparam int OFF_W = 4;
    localparam int NUM_OFF = 10;
    localparam int ONES_LEN = 10;
    localparam int ZEROS_LEN = 20;
    localparam int HIST_W = 9;
    localparam int TAP_MID = 5;
    localparam logic [1:0] TRS_REST = 2'h3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam int CTRL_W = 3;
    localparam int IRQ_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

    typedef enum logic [0:0] {
        HUNT = 1'b0,
        LOCKED = 1'b1
    } framing_type;

    typedef struct packed {
        logic asi_mode;
        logic bypass;
        logic filter_sel;
    } ctrl_type;

    // irq bits: nsp rise, realign, filtered error, preamble
    typedef struct packed {
        logic nsp_rise;
        logic realign;
        logic filt_err;
        logic preamble;
    } irq_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic timing_mark;
        logic framed;
        logic new_offset;
        logic line_toggle;
        logic filter_err;
    } video_status_type;
endpackage : sdi_framer_pkg
`default_nettype wire

// ### sdi_parallel_framer_decoder.sv
// Our own choices: the address-and-strobe port and the register addresses.
`default_nettype none
module sdi_parallel_framer_decoder
    import sdi_framer_pkg::*;
(
    // clock, reset, enable
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CE,
    // register port
    input wire reg_req_type REG_REQ,
    output logic [DATA_W-1:0] RDATA,
    output logic IRQ,
    // video words
    input wire logic [WORD_W-1:0] DIN,
    output logic [WORD_W-1:0] DOUT,
    // status
    output video_status_type STATUS,
    output logic RECEIVER_MODE_OUT
);

    // =========================================================
    // helpers
    // =========================================================
    function automatic logic [NUM_OFF-1:0] find_hits(input logic [VEC_W-1:0] v);
        logic [NUM_OFF-1:0] h;
        h = '0;
        for (int k = 0; k < NUM_OFF; k++) begin
            h[k] = (&v[k +: ONES_LEN]) & ~(|v[k + ONES_LEN +: ZEROS_LEN]); // RULE14
        end
        return h;
    endfunction

    function automatic logic [OFF_W-1:0] encode(input logic [NUM_OFF-1:0] h);
        logic [OFF_W-1:0] o;
        o = '0;
        for (int k = NUM_OFF - 1; k >= 0; k--) begin
            if (h[k]) begin
                o = OFF_W'(k);
            end
        end
        return o;
    endfunction

    function automatic logic [WORD_W-1:0] shift_out(
        input logic [SLICE_W-1:0] s,
        input logic [OFF_W-1:0] o
    );
        return s[o +: WORD_W];
    endfunction

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic nrzi_last;
        logic [HIST_W-1:0] nrz_hist;
        logic [WORD_W-1:0] desc;
        logic [WORD_W-1:0] pipe_stage_one;
        logic [WORD_W-1:0] pipe_stage_two;
        logic [WORD_W-1:0] pipe_stage_three;
        logic [OFF_W-1:0] offset;
        logic nsp;
        framing_type framing;
        logic [1:0] trs_cnt;
        logic [WORD_W-1:0] dout;
        video_status_type stat;
        logic receiver_mode_echo;
        ctrl_type ctrl;
        irq_type irq_stat;
        irq_type irq_mask;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } state_type;

    localparam state_type STATE_RESET = '{
        nrzi_last: 1'b0, nrz_hist: '0, desc: '0,
        pipe_stage_one: '0, pipe_stage_two: '0, pipe_stage_three: '0,
        offset: '0, nsp: 1'b0, framing: HUNT, trs_cnt: '0, dout: '0,
        stat: '0, receiver_mode_echo: 1'b1, ctrl: CTRL_RESET,
        irq_stat: '0, irq_mask: '0, irq: 1'b0, rdata: '0
    };

    state_type q;
    state_type d;

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        logic [WORD_W-1:0] nrz;
        logic [SLICE_W-1:0] chain;
        logic [WORD_W-1:0] descr;
        logic [VEC_W-1:0] vec;
        logic [NUM_OFF-1:0] hits;
        logic found;
        logic [OFF_W-1:0] enc;
        logic differs;
        logic realign_ok;
        logic realign;
        logic filtered;
        logic [OFF_W-1:0] use_off;
        logic pass_through;
        irq_type ev;
        irq_type w1c;
        logic [DATA_W-1:0] rd_val;
        nrz = '0;
        chain = '0;
        descr = '0;
        vec = '0;
        hits = '0;
        found = 1'b0;
        enc = '0;
        differs = 1'b0;
        realign_ok = 1'b0;
        realign = 1'b0;
        filtered = 1'b0;
        use_off = '0;
        pass_through = 1'b0;
        d = q;
        ev = '0;
        w1c = '0;
        rd_val = '0;

        // descrambler: nrzi to nrz, then x^9 + x^4 + 1
        nrz = DIN ^ {DIN[WORD_W-2:0], q.nrzi_last};
        chain = {nrz, q.nrz_hist};
        for (int i = 0; i < WORD_W; i++) begin
            descr[i] = chain[i + HIST_W] ^ chain[i + TAP_MID] ^ chain[i];
        end
        d.nrzi_last = DIN[WORD_W-1];
        d.nrz_hist = nrz[WORD_W-1:1];
        d.desc = descr; // RULE6

        // preamble search over pipelined descrambled words
        d.pipe_stage_one = q.desc; // RULE1
        d.pipe_stage_two = q.pipe_stage_one;
        d.pipe_stage_three = q.pipe_stage_two;
        vec = {q.desc[HIST_W-1:0], q.pipe_stage_one,
               q.pipe_stage_two, q.pipe_stage_three}; // RULE2
        hits = find_hits(vec);
        found = |hits;
        enc = encode(hits); // RULE3
        differs = (enc != q.offset); // RULE3

        // filter low: always allowed; high: allowed only while flag is up
        realign_ok = q.ctrl.filter_sel ? q.nsp : 1'b1; // RULE18 RULE7
        realign = found && differs && realign_ok; // RULE4
        filtered = found && differs && !realign_ok; // RULE16

        if (found) begin
            d.nsp = filtered; // RULE15 RULE4
            d.framing = LOCKED; // RULE19
        end
        if (realign) begin
            d.offset = enc; // RULE4
        end

        // shifter takes the new offset at once when realigning
        use_off = realign ? enc : q.offset;

        // timing marker across the four preamble words
        if (found) begin
            d.stat.timing_mark = 1'b1; // RULE17
            d.trs_cnt = TRS_REST;
        end else if (q.trs_cnt != '0) begin
            d.stat.timing_mark = 1'b1;
            d.trs_cnt = q.trs_cnt - 2'h1;
        end else begin
            d.stat.timing_mark = 1'b0;
        end

        // output mux ahead of the output register
        pass_through = q.ctrl.asi_mode || q.ctrl.bypass; // RULE8 RULE9
        if (pass_through) begin
            d.dout = DIN; // RULE8 RULE9
        end else begin
            d.dout = shift_out({q.pipe_stage_two[HIST_W-1:0], q.pipe_stage_three},
                               use_off); // RULE5
        end

        d.stat.framed = (d.framing == LOCKED) && !d.nsp;
        d.stat.new_offset = d.nsp;
        if (found && q.ctrl.asi_mode) begin
            d.stat.line_toggle = !q.stat.line_toggle; // RULE11 RULE12
        end
        d.stat.filter_err = filtered && q.ctrl.filter_sel; // RULE13
        d.receiver_mode_echo = !q.ctrl.asi_mode; // RULE10

        // register writes
        if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                OFS_CTRL: d.ctrl = ctrl_type'(REG_REQ.wdata[CTRL_W-1:0]);
                OFS_IRQ_STAT: w1c = irq_type'(REG_REQ.wdata[IRQ_W-1:0]);
                OFS_IRQ_MASK: d.irq_mask = irq_type'(REG_REQ.wdata[IRQ_W-1:0]);
                default: ;
            endcase
        end

        // sticky events; a set in the clearing cycle wins
        ev.preamble = found;
        ev.filt_err = filtered && q.ctrl.filter_sel;
        ev.realign = realign;
        ev.nsp_rise = filtered && !q.nsp;
        d.irq_stat = (q.irq_stat & ~w1c) | ev;
        d.irq = |(d.irq_stat & d.irq_mask);

        // register reads, answered next cycle
        case (REG_REQ.addr)
            OFS_CTRL: rd_val = DATA_W'(q.ctrl);
            OFS_STATUS: rd_val = DATA_W'({q.receiver_mode_echo, q.stat.line_toggle,
                                          q.stat.framed, q.nsp, q.offset});
            OFS_IRQ_STAT: rd_val = DATA_W'(q.irq_stat);
            OFS_IRQ_MASK: rd_val = DATA_W'(q.irq_mask);
            default: rd_val = '0;
        endcase
        d.rdata = REG_REQ.rd ? rd_val : '0;
    end

    // =========================================================
    // registers
    // =========================================================
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            q <= STATE_RESET; // RULE19
        end else if (CE) begin
            q <= d;
        end
    end

    assign RDATA = q.rdata;
    assign IRQ = q.irq;
    assign DOUT = q.dout;
    assign STATUS = q.stat;
    assign RECEIVER_MODE_OUT = q.receiver_mode_echo;

endmodule // sdi_parallel_framer_decoder
`default_nettype wire

// ### sdi_scrambler_model.sv
`default_nettype none
// ========================================
// scrambler and nrzi encoder feeding the decoder
module sdi_scrambler_model (
    // clock
    input wire logic clk,
    // words, bit 0 first in time
    input wire logic [9:0] raw,
    output logic [9:0] enc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] hist_q = 9'h000;
    logic nrzi_q = 1'b0;
    always_ff @(posedge clk) begin
        logic [8:0] h;
        logic n;
        logic s;
        h = hist_q;
        n = nrzi_q;
        for (int i = 0; i < 10; i++) begin
            s = raw[i] ^ h[3] ^ h[8];
            h = {h[7:0], s};
            n = n ^ s;
            enc[i] <= n;
        end
        hist_q <= h;
        nrzi_q <= n;
    end
endmodule // sdi_scrambler_model
`default_nettype wire

// ### sdi_framer_decoder_props.sv
`default_nettype none
// ========================================
// port checker
module sdi_framer_decoder_props
    import sdi_framer_pkg::*;
(
    // clock, reset and enable
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic CE,
    // register port
    input wire reg_req_type REG_REQ,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic IRQ,
    // video
    input wire logic [WORD_W-1:0] DOUT,
    input wire video_status_type STATUS,
    input wire logic RECEIVER_MODE_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    logic asi_q;
    logic ctrl_wr;
    assign ctrl_wr = CE && REG_REQ.wr && REG_REQ.addr == OFS_CTRL;
    always_ff @(posedge CLOCK) begin
        if (!RST_B) asi_q <= 1'b0;
        else if (ctrl_wr) asi_q <= REG_REQ.wdata[2];
    end
    property p_echo; ctrl_wr |-> ##[1:2] RECEIVER_MODE_OUT == !asi_q; endproperty
    a_echo: assert property (p_echo) else $error("mode echo wrong");
    property p_err; STATUS.filter_err |=> !STATUS.filter_err; endproperty
    a_err: assert property (p_err) else $error("error pulse too long");
    property p_tm;
        $rose(STATUS.timing_mark) |-> STATUS.timing_mark[*4] ##1 !STATUS.timing_mark;
    endproperty
    a_tm: assert property (p_tm) else $error("marker length wrong");
    property p_rd; CE && !REG_REQ.rd |=> RDATA == '0; endproperty
    a_rd: assert property (p_rd) else $error("read data not cleared");
    property p_irq;
        CE && REG_REQ.wr && REG_REQ.addr == OFS_IRQ_MASK && REG_REQ.wdata[IRQ_W-1:0] == '0
            |=> !IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("masked irq high");
    property p_hold; !asi_q && !$past(asi_q) |-> $stable(STATUS.line_toggle); endproperty
    a_hold: assert property (p_hold) else $error("toggle moved");
    property p_nsp; STATUS.new_offset |-> !STATUS.framed; endproperty
    a_nsp: assert property (p_nsp) else $error("framed with new offset");
    property p_rst; disable iff (1'b0) !RST_B |=> DOUT == '0 && STATUS == '0; endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule // sdi_framer_decoder_props
bind sdi_parallel_framer_decoder sdi_framer_decoder_props i_props (.CLOCK(CLOCK),
    .RST_B(RST_B), .CE(CE), .REG_REQ(REG_REQ), .RDATA(RDATA), .IRQ(IRQ), .DOUT(DOUT),
    .STATUS(STATUS), .RECEIVER_MODE_OUT(RECEIVER_MODE_OUT));
`default_nettype wire

// ### testbench.sv
`default_nettype none
// ========================================
// bench
module testbench;
    import sdi_framer_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    reg_req_type req = '0;
    logic [DATA_W-1:0] rdata;
    logic irq, rmode;
    logic [9:0] raw = 10'h200;
    logic [9:0] acc = '0;
    logic [WORD_W-1:0] din, dout;
    video_status_type st;
    logic [9:0] wq[$];
    int na = 0;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [40:0] rows[10] = '{{1'b1, OFS_CTRL, 32'hFFFFFFFF}, {1'b0, OFS_CTRL, 32'h7},
        {1'b1, OFS_IRQ_MASK, 32'hFFFFFFFF}, {1'b1, 8'h10, 32'hFFFFFFFF}, {1'b0, 8'h10, 32'h0},
        {1'b0, OFS_IRQ_MASK, 32'hF}, {1'b1, OFS_CTRL, 32'h0}, {1'b0, OFS_CTRL, 32'h0},
        {1'b1, OFS_IRQ_STAT, 32'hF}, {1'b0, OFS_IRQ_STAT, 32'h0}};
    always #2 clock = ~clock;
    sdi_scrambler_model i_model (.clk(clock), .raw(raw), .enc(din));
    sdi_parallel_framer_decoder i_dut (.CLOCK(clock), .RST_B(rst_b), .CE(1'b1), .REG_REQ(req),
        .RDATA(rdata), .IRQ(irq), .DIN(din), .DOUT(dout), .STATUS(st), .RECEIVER_MODE_OUT(rmode));
    // filler word never holds ten ones in a row
    always @(posedge clock) begin
        raw <= wq.size() > 0 ? wq.pop_front() : 10'h200;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m);
        @(posedge clock);
        req <= '{a, d, w, !w};
        @(posedge clock);
        req <= '0;
        #1;
        if (!w) chk(rdata & m, d & m);
    endtask
    task automatic put(input logic [39:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            acc[na] = v[i];
            na++;
            if (na == 10) begin
                wq.push_back(acc);
                na = 0;
            end
        end
    endtask
    task automatic trs(input int o, input logic f, input logic [1:0] e);
        put('0, o);
        put({10'h274, 20'h00000, 10'h3FF}, 40);
        put('0, (10 - o) % 10);
        for (int k = 0; k < 60; k++) begin
            @(posedge clock);
            #1;
            if (st.timing_mark === 1'b1) break;
        end
        chk({st.filter_err, st.new_offset}, e);
        if (f) chk(dout, 10'h3FF);
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            #1;
            chk(st.timing_mark, 1'b1);
        end
        if (f) chk(dout, 10'h274);
    endtask
    task automatic pass();
        logic [9:0] p;
        #1;
        p = din;
        for (int k = 0; k < 8; k++) begin
            @(posedge clock);
            #1;
            chk(dout, p);
            p = din;
        end
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        #1;
        chk({rmode, dout, st}, 32'h8000);
        foreach (rows[i]) bus(rows[i][40], rows[i][39:32], rows[i][31:0], '1);
        trs(3, 1'b1, 2'b00);
        bus(1'b0, OFS_STATUS, 32'h23, 32'h7F);
        bus(1'b1, OFS_IRQ_MASK, 32'h2, '1);
        bus(1'b1, OFS_IRQ_STAT, 32'hF, '1);
        bus(1'b1, OFS_CTRL, 32'h1, '1);
        trs(3, 1'b1, 2'b00);
        chk(irq, 1'b0);
        trs(7, 1'b0, 2'b11);
        chk(irq, 1'b1);
        bus(1'b0, OFS_STATUS, 32'h13, 32'h3F);
        trs(7, 1'b1, 2'b00);
        bus(1'b0, OFS_STATUS, 32'h27, 32'h3F);
        bus(1'b1, OFS_IRQ_STAT, 32'hF, '1);
        #1 chk(irq, 1'b0);
        bus(1'b1, OFS_IRQ_MASK, 32'h0, '1);
        bus(1'b1, OFS_CTRL, 32'h0, '1);
        trs(1, 1'b1, 2'b00);
        bus(1'b1, OFS_CTRL, 32'h2, '1);
        pass();
        bus(1'b1, OFS_CTRL, 32'h4, '1);
        pass();
        chk(rmode, 1'b0);
        trs(5, 1'b0, 2'b00);
        chk(st.line_toggle, 1'b1);
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk({rmode, dout, st}, 32'h8000);
        stop_test();
    end
endmodule // testbench
`default_nettype wire
